// [nrid_host.sv]
`timescale 1ns/10ps
// What this block does
// - Wait for ready/busy valid and high before first reset command.
// - Without watching ready/busy, wait 100us after supply is good; else wait high.
// - Reset FFh is the very first command to the target.
// - After polling with 70h, except for reset, issue 00h to restore data output.
// - Never issue 78h during parameter page busy or data output.
// - Random data read 05h-E0h moves the output position.
// - Check CRC of each parameter copy, moving on after mismatch.
// - XOR copy halves; accept when all sixteen results are FFh.
module nrid_host #(
  parameter int PWR_WAIT = nrid_pkg::PWR_WAIT_CYC,
  parameter int RST_BUSY = nrid_pkg::RST_BUSY_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // User orders
  input wire logic op_valid,
  output logic op_ready,
  input wire logic [2:0] op_code,
  input wire logic op_poll,
  input wire logic [15:0] op_col,
  input wire logic [9:0] op_len,
  output logic op_done,
  output logic [7:0] status_q,
  output logic init_done_q,
  // Read data stream
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data,
  // Check results
  output logic crc_ok_q,
  output logic uid_ok_q,
  // Flash pins
  output logic ce_n_q,
  output logic cle_q,
  output logic ale_q,
  output logic write_strobe_n_q,
  output logic read_strobe_n_q,
  output logic [7:0] io_out_q,
  output logic io_oe_q,
  input wire logic [7:0] io_in,
  input wire logic ready_busy_n
);
  // =====================================================================
  // Reset release
  // =====================================================================
  logic rst_s1_q;
  logic rst_n;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // =====================================================================
  // Sequencer
  // =====================================================================
  nrid_pkg::nrid_state_type state_q;
  logic [7:0] cmd_q;
  logic [1:0] addr_n_q;
  logic [1:0] addr_i_q;
  logic [15:0] addr_q;
  logic [9:0] left_q;
  logic [9:0] idx_q;
  logic stat_rdy_q;
  logic [3:0] ph_q;
  logic wphase_q;
  logic [2:0] op_q;
  logic poll_q;
  logic [31:0] tmr_q;
  logic pwr_ok_q;
  logic fifo_in_ready;
  logic push_q;
  logic [7:0] push_data_q;

  assign op_ready = (state_q == nrid_pkg::NRID_IDLE) && pwr_ok_q;
  assign op_done = (state_q == nrid_pkg::NRID_DONE);

  // Power-up wait; orders accepted before the first reset are dropped without reaching the flash
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_q <= '0;
      pwr_ok_q <= 1'b0;
    end else if (!pwr_ok_q) begin
      tmr_q <= tmr_q + 32'h1;
      if (tmr_q >= 32'(PWR_WAIT) && ready_busy_n) begin
        pwr_ok_q <= 1'b1;
      end
    end else if (state_q == nrid_pkg::NRID_WAIT) begin
      tmr_q <= tmr_q + 32'h1;
    end else begin
      tmr_q <= '0;
    end
  end

  function automatic logic [7:0] op_cmd(input logic [2:0] op);
    unique case (op)
      nrid_pkg::OP_RESET: op_cmd = nrid_pkg::CMD_RESET;
      nrid_pkg::OP_ID_MAKER, nrid_pkg::OP_ID_ONFI: op_cmd = nrid_pkg::CMD_READ_ID;
      nrid_pkg::OP_PARAM: op_cmd = nrid_pkg::CMD_PARAM_PAGE;
      nrid_pkg::OP_UNIQUE: op_cmd = nrid_pkg::CMD_UNIQUE_ID;
      nrid_pkg::OP_STATUS: op_cmd = nrid_pkg::CMD_STATUS;
      nrid_pkg::OP_RAND_READ: op_cmd = nrid_pkg::CMD_RAND_READ;
      default: op_cmd = nrid_pkg::CMD_STATUS;
    endcase
  endfunction : op_cmd

  // One pin cycle: strobe low for STROBE_CNT+1 clocks, then high as long
  wire logic step_end = (ph_q == nrid_pkg::STROBE_CNT) && wphase_q;
  wire logic busy_wait = (op_q == nrid_pkg::OP_RESET) || (op_q == nrid_pkg::OP_PARAM)
                         || (op_q == nrid_pkg::OP_UNIQUE);
  // A copy that fails its check is followed by the next one, up to the last copy
  wire logic retry_copy = (op_q == nrid_pkg::OP_PARAM && !crc_ok_q && idx_q[9:8] != 2'h3)
                          || (op_q == nrid_pkg::OP_UNIQUE && !uid_ok_q && idx_q[9:5] != 5'h10);
  wire logic stat_wr = (state_q == nrid_pkg::NRID_STAT) && (cmd_q == nrid_pkg::CMD_STATUS);
  wire logic mode_wr = (state_q == nrid_pkg::NRID_MODE) && poll_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= nrid_pkg::NRID_IDLE;
      cmd_q <= '0;
      addr_n_q <= '0;
      addr_i_q <= '0;
      addr_q <= '0;
      left_q <= '0;
      ph_q <= '0;
      wphase_q <= 1'b0;
      op_q <= '0;
      poll_q <= 1'b0;
      stat_rdy_q <= 1'b0;
      init_done_q <= 1'b0;
      status_q <= '0;
      push_q <= 1'b0;
      push_data_q <= '0;
    end else begin
      push_q <= 1'b0;
      if (state_q inside {nrid_pkg::NRID_CMD, nrid_pkg::NRID_ADDR, nrid_pkg::NRID_STAT,
                          nrid_pkg::NRID_MODE, nrid_pkg::NRID_READ, nrid_pkg::NRID_RCMD}) begin
        if (ph_q == nrid_pkg::STROBE_CNT) begin
          ph_q <= nrid_pkg::ZERO_CNT4;
          wphase_q <= !wphase_q;
        end else begin
          ph_q <= ph_q + 4'h1;
        end
      end else begin
        ph_q <= nrid_pkg::ZERO_CNT4;
        wphase_q <= 1'b0;
      end
      unique case (state_q)
        nrid_pkg::NRID_IDLE: begin
          if (op_valid && op_ready && (init_done_q || op_code == nrid_pkg::OP_RESET)) begin
            op_q <= op_code;
            poll_q <= op_poll;
            cmd_q <= op_cmd(op_code);
            addr_q <= (op_code == nrid_pkg::OP_ID_ONFI) ? {8'h00, nrid_pkg::ADDR_ID_ONFI} : op_col;
            addr_n_q <= (op_code == nrid_pkg::OP_RAND_READ) ? 2'h2
                      : (op_code == nrid_pkg::OP_RESET || op_code == nrid_pkg::OP_STATUS) ? 2'h0 : 2'h1;
            addr_i_q <= '0;
            unique case (op_code)
              nrid_pkg::OP_ID_MAKER: left_q <= nrid_pkg::LEN_ID_MAKER;
              nrid_pkg::OP_ID_ONFI: left_q <= nrid_pkg::LEN_ID_ONFI;
              nrid_pkg::OP_PARAM: left_q <= nrid_pkg::LEN_PARAM;
              nrid_pkg::OP_UNIQUE: left_q <= nrid_pkg::LEN_UNIQUE;
              nrid_pkg::OP_STATUS: left_q <= 10'h001;
              default: left_q <= op_len;
            endcase
            state_q <= nrid_pkg::NRID_CMD;
          end else if (op_valid && op_ready) begin
            state_q <= nrid_pkg::NRID_DONE;
          end
        end
        nrid_pkg::NRID_CMD: begin
          if (step_end) begin
            if (addr_n_q != 2'h0) begin
              state_q <= nrid_pkg::NRID_ADDR;
            end else if (op_q == nrid_pkg::OP_STATUS) begin
              state_q <= nrid_pkg::NRID_READ;
            end else begin
              state_q <= nrid_pkg::NRID_WAIT;
            end
          end
        end
        nrid_pkg::NRID_ADDR: begin
          if (step_end) begin
            addr_q <= {8'h00, addr_q[15:8]};
            addr_i_q <= addr_i_q + 2'h1;
            if (addr_i_q + 2'h1 == addr_n_q) begin
              state_q <= (op_q == nrid_pkg::OP_RAND_READ) ? nrid_pkg::NRID_RCMD
                       : busy_wait ? nrid_pkg::NRID_WAIT : nrid_pkg::NRID_READ;
            end
          end
        end
        nrid_pkg::NRID_RCMD: begin
          if (step_end) begin
            state_q <= nrid_pkg::NRID_READ;
          end
        end
        nrid_pkg::NRID_WAIT: begin
          // Give the target a few clocks to pull busy low before trusting it
          if (tmr_q > 32'h10 && (poll_q ? 1'b1 : ready_busy_n)) begin
            state_q <= poll_q ? nrid_pkg::NRID_STAT : nrid_pkg::NRID_MODE;
            cmd_q <= nrid_pkg::CMD_STATUS;
          end else if (op_q == nrid_pkg::OP_RESET && tmr_q >= 32'(RST_BUSY) && ready_busy_n) begin
            state_q <= nrid_pkg::NRID_MODE;
          end
        end
        nrid_pkg::NRID_STAT: begin
          // Status 70h then one status read; loop until ready
          if (!wphase_q && ph_q == nrid_pkg::STROBE_CNT && cmd_q != nrid_pkg::CMD_STATUS) begin
            stat_rdy_q <= io_in[nrid_pkg::STAT_RDY_BIT];
          end
          if (step_end && cmd_q == nrid_pkg::CMD_STATUS) begin
            cmd_q <= nrid_pkg::CMD_READ_MODE;
          end else if (step_end) begin
            cmd_q <= nrid_pkg::CMD_STATUS;
            if (stat_rdy_q) begin
              state_q <= nrid_pkg::NRID_MODE;
            end
          end
        end
        nrid_pkg::NRID_MODE: begin
          if (op_q == nrid_pkg::OP_RESET) begin
            init_done_q <= 1'b1;
            status_q <= nrid_pkg::STAT_RST_WP_HI;
            state_q <= nrid_pkg::NRID_DONE;
          end else if (!poll_q || step_end) begin
            state_q <= (op_q == nrid_pkg::OP_RESET) ? nrid_pkg::NRID_DONE : nrid_pkg::NRID_READ;
          end
        end
        nrid_pkg::NRID_READ: begin
          // Sample just before the strobe rises; stall while the FIFO is full
          if (!wphase_q && ph_q == nrid_pkg::STROBE_CNT) begin
            if (!fifo_in_ready) begin
              ph_q <= ph_q;
              wphase_q <= wphase_q;
            end else begin
              push_q <= (op_q != nrid_pkg::OP_STATUS);
              push_data_q <= io_in;
              if (op_q == nrid_pkg::OP_STATUS) begin
                status_q <= io_in;
              end
            end
          end
          if (step_end) begin
            left_q <= left_q - 10'h001;
            if (left_q == 10'h001 && retry_copy) begin
              left_q <= (op_q == nrid_pkg::OP_PARAM) ? nrid_pkg::LEN_PARAM : nrid_pkg::LEN_UNIQUE;
            end else if (left_q == 10'h001) begin
              state_q <= nrid_pkg::NRID_DONE;
            end
          end
        end
        nrid_pkg::NRID_DONE: begin
          state_q <= nrid_pkg::NRID_IDLE;
        end
      endcase
    end
  end

  // =====================================================================
  // Pin drive; 78h is never produced by this controller
  // =====================================================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ce_n_q <= 1'b1;
      cle_q <= 1'b0;
      ale_q <= 1'b0;
      write_strobe_n_q <= 1'b1;
      read_strobe_n_q <= 1'b1;
      io_out_q <= '0;
      io_oe_q <= 1'b0;
    end else begin
      ce_n_q <= (state_q == nrid_pkg::NRID_IDLE) || (state_q == nrid_pkg::NRID_DONE);
      cle_q <= (state_q inside {nrid_pkg::NRID_CMD, nrid_pkg::NRID_RCMD}) || mode_wr || stat_wr;
      ale_q <= (state_q == nrid_pkg::NRID_ADDR);
      write_strobe_n_q <= !(((state_q inside {nrid_pkg::NRID_CMD, nrid_pkg::NRID_ADDR, nrid_pkg::NRID_RCMD})
                             || mode_wr || stat_wr) && !wphase_q);
      read_strobe_n_q <= !(((state_q == nrid_pkg::NRID_READ)
                            || (state_q == nrid_pkg::NRID_STAT && !stat_wr)) && !wphase_q);
      io_oe_q <= (state_q inside {nrid_pkg::NRID_CMD, nrid_pkg::NRID_ADDR, nrid_pkg::NRID_RCMD})
                 || mode_wr || stat_wr;
      unique case (state_q)
        nrid_pkg::NRID_ADDR: io_out_q <= addr_q[7:0];
        nrid_pkg::NRID_RCMD: io_out_q <= nrid_pkg::CMD_RAND_CONF;
        nrid_pkg::NRID_MODE: io_out_q <= nrid_pkg::CMD_READ_MODE;
        default: io_out_q <= cmd_q;
      endcase
    end
  end

  // =====================================================================
  // Stream checks on the way to the user
  // =====================================================================
  logic [15:0] crc_q;
  logic crc_lo_ok_q;
  logic [7:0] uid_q [16];
  logic uid_bad_q;
  wire logic [15:0] crc_nx = crc_step(crc_q, push_data_q);

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int b = 7; b >= 0; b--) begin
      r = (r[15] ^ d[b]) ? {r[14:0], 1'b0} ^ 16'h8005 : {r[14:0], 1'b0};
    end
    return r;
  endfunction : crc_step

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_q <= 16'h4F4E;
      idx_q <= '0;
      crc_ok_q <= 1'b0;
      crc_lo_ok_q <= 1'b0;
      uid_ok_q <= 1'b0;
      uid_bad_q <= 1'b0;
      for (int i = 0; i < 16; i++) begin
        uid_q[i] <= '0;
      end
    end else if (state_q == nrid_pkg::NRID_CMD) begin
      crc_q <= 16'h4F4E;
      idx_q <= '0;
      uid_bad_q <= 1'b0;
    end else if (push_q) begin
      idx_q <= idx_q + 10'h001;
      if (op_q == nrid_pkg::OP_PARAM && idx_q[7:0] < 8'hFE) begin
        crc_q <= crc_nx;
      end
      if (op_q == nrid_pkg::OP_PARAM && idx_q[7:0] == 8'hFE) begin
        crc_lo_ok_q <= (crc_q[7:0] == push_data_q);
      end
      if (op_q == nrid_pkg::OP_PARAM && idx_q[7:0] == 8'hFF) begin
        crc_ok_q <= crc_lo_ok_q && (crc_q[15:8] == push_data_q);
        // Each copy is checked on its own
        crc_q <= 16'h4F4E;
      end
      if (op_q == nrid_pkg::OP_UNIQUE && !idx_q[4]) begin
        uid_q[idx_q[3:0]] <= push_data_q;
      end
      if (op_q == nrid_pkg::OP_UNIQUE && idx_q[4]) begin
        if ((uid_q[idx_q[3:0]] ^ push_data_q) != 8'hFF) begin
          uid_bad_q <= 1'b1;
        end
        if (idx_q[4:0] == 5'h1F) begin
          uid_ok_q <= !uid_bad_q && ((uid_q[15] ^ push_data_q) == 8'hFF);
          uid_bad_q <= 1'b0;
        end
      end
    end
  end

  nrid_fifo #(.WIDTH(8), .DEPTH(4)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(push_q),
    .in_ready(fifo_in_ready),
    .in_data(push_data_q),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  // =====================================================================
  // Checks
  // =====================================================================
  no_op_before_pwr_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q != nrid_pkg::NRID_IDLE && !$past(pwr_ok_q, 1)) |-> 1'b0 || pwr_ok_q)
    else $error("order started before power-up wait");
  first_is_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == nrid_pkg::NRID_CMD && !init_done_q) |-> cmd_q == nrid_pkg::CMD_RESET)
    else $error("first command is not reset");
  no_enh_status_a: assert property (@(posedge clk) disable iff (!rst_n)
    (io_oe_q && cle_q) |-> io_out_q != nrid_pkg::CMD_STATUS_ENH)
    else $error("enhanced status issued");
  strobes_apart_a: assert property (@(posedge clk) disable iff (!rst_n)
    !read_strobe_n_q |-> (!cle_q && !ale_q && write_strobe_n_q && !io_oe_q))
    else $error("read strobe with latches or drive active");
  busy_wait_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == nrid_pkg::NRID_WAIT && $past(state_q) == nrid_pkg::NRID_WAIT)
    |-> (write_strobe_n_q && read_strobe_n_q))
    else $error("strobe toggled during busy wait");
  stream_held_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_valid && !rd_ready) |=> (rd_valid && $stable(rd_data)))
    else $error("read byte dropped before taken");
endmodule : nrid_host

// [nrid_pkg.sv]
package nrid_pkg;

  // =====================================================================
  // Command codes
  // =====================================================================
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_STATUS_ENH = 8'h78;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_PARAM_PAGE = 8'hEC;
  localparam logic [7:0] CMD_UNIQUE_ID = 8'hED;
  localparam logic [7:0] CMD_READ_MODE = 8'h00;
  localparam logic [7:0] CMD_RAND_READ = 8'h05;
  localparam logic [7:0] CMD_RAND_CONF = 8'hE0;
  localparam logic [7:0] ADDR_ID_MAKER = 8'h00;
  localparam logic [7:0] ADDR_ID_ONFI = 8'h20;

  // Status register values after reset, and its ready bit
  localparam logic [7:0] STAT_RST_WP_HI = 8'hE0;
  localparam logic [7:0] STAT_RST_WP_LO = 8'h60;
  localparam int STAT_RDY_BIT = 6;

  // =====================================================================
  // User operations
  // =====================================================================
  localparam logic [2:0] OP_RESET = 3'h0;
  localparam logic [2:0] OP_ID_MAKER = 3'h1;
  localparam logic [2:0] OP_ID_ONFI = 3'h2;
  localparam logic [2:0] OP_PARAM = 3'h3;
  localparam logic [2:0] OP_UNIQUE = 3'h4;
  localparam logic [2:0] OP_STATUS = 3'h5;
  localparam logic [2:0] OP_RAND_READ = 3'h6;

  // =====================================================================
  // Timing (250 MHz, 4 ns)
  // =====================================================================
  localparam int CLK_PS = 4000;
  localparam int RB_VALID_US = 50;
  localparam int PWR_WAIT_US = 100;
  localparam int RST_BUSY_US = 1000;
  localparam int STROBE_NS = 25;
  localparam int PWR_WAIT_CYC = (PWR_WAIT_US * 1000000 + CLK_PS - 1) / CLK_PS;
  localparam int RST_BUSY_CYC = (RST_BUSY_US * 1000000) / CLK_PS;
  localparam int STROBE_CYC = (STROBE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC);
  localparam logic [3:0] ZERO_CNT4 = 4'h0;

  // Byte counts per read
  localparam logic [9:0] LEN_ID_MAKER = 10'h005;
  localparam logic [9:0] LEN_ID_ONFI = 10'h004;
  localparam logic [9:0] LEN_PARAM = 10'h100;
  localparam logic [9:0] LEN_UNIQUE = 10'h020;

  typedef enum logic [8:0] {
    NRID_IDLE = 9'h001,
    NRID_CMD = 9'h002,
    NRID_ADDR = 9'h004,
    NRID_WAIT = 9'h008,
    NRID_STAT = 9'h010,
    NRID_MODE = 9'h020,
    NRID_READ = 9'h040,
    NRID_RCMD = 9'h080,
    NRID_DONE = 9'h100
  } nrid_state_type;

endpackage : nrid_pkg

// [nrid_fifo.sv]
`timescale 1ns/10ps
module nrid_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : nrid_fifo

// [nrid_flash_model.sv]
`timescale 1ns/10ps
module nrid_flash_model #(
  parameter logic [7:0] MAKER_ID = 8'hA5, // Arbitrary value
  parameter logic [7:0] DEVICE_ID = 8'h3C, // Arbitrary value
  parameter int PWRUP_NS = 400,
  parameter int RST_NS = 300,
  parameter int ARRAY_NS = 200
) (
  // Host pins, and bad_copy0 to damage the first copy
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic [7:0] dq_in,
  input wire logic bad_copy0,
  // Device pins
  output logic [7:0] dq_out,
  output logic dq_oe,
  output logic ready_busy_n
);
  logic [7:0] mem [0:1023];
  logic [7:0] last_cmd = 8'h00;
  logic [15:0] col = 16'h0000;
  logic [15:0] crc;
  logic [9:0] ptr = 10'h000;
  logic busy = 1'b1;
  logic stat_mode = 1'b0;
  int gen = 0;
  int nadr = 0;
  // Write protect tied high, so E0h when ready
  wire logic [7:0] status = {1'b1, ~busy, ~busy, 5'h00};

  assign ready_busy_n = ~busy;

  // A later busy period cancels the end of an earlier one
  task automatic go_busy(input int ns);
    int g;
    gen++;
    g = gen;
    busy = 1'b1;
    fork
      begin
        #(ns);
        if (g == gen) busy = 1'b0;
      end
    join_none
  endtask : go_busy

  task automatic fill(input logic [7:0] c, input logic [7:0] a);
    for (int i = 0; i < 1024; i++) mem[i] = ~8'(i);
    if (c == 8'h90 && a == 8'h00) {mem[0], mem[1], mem[2], mem[3], mem[4]} = {MAKER_ID, DEVICE_ID, 24'h909506};
    if (c == 8'h90 && a == 8'h20) {mem[0], mem[1], mem[2], mem[3]} = 32'h4F4E4649;
    if (c == 8'hEC) begin
      for (int j = 0; j < 254; j++) mem[j] = j < 4 ? 8'(32'h4F4E4649 >> (24 - 8 * j)) : 8'(j);
      crc = 16'h4F4E;
      for (int j = 0; j < 254; j++) begin
        crc ^= {mem[j], 8'h00};
        repeat (8) crc = crc[15] ? {crc[14:0], 1'b0} ^ 16'h8005 : {crc[14:0], 1'b0};
      end
      {mem[255], mem[254]} = crc;
      for (int j = 256; j < 768; j++) mem[j] = mem[j - 256];
      mem[10] ^= {7'h00, bad_copy0};
    end
    if (c == 8'hED) begin
      for (int j = 0; j < 512; j++) mem[j] = 8'(j % 16 + j / 32 * 16) ^ (j % 32 < 16 ? 8'h5A : 8'hA5);
      mem[3] ^= {7'h00, bad_copy0};
    end
  endtask : fill

  always @(posedge write_strobe_n) begin
    if (!ce_n && cle && (!busy || dq_in inside {8'h70, 8'h78, 8'hFF})) begin
      last_cmd = dq_in;
      nadr = 0;
      stat_mode = (dq_in == 8'h70);
      if (dq_in == 8'hFF) begin
        ptr = 10'h000;
        fill(8'hFF, 8'h00);
        go_busy(RST_NS);
      end
      if (dq_in == 8'hE0) ptr = col[9:0];
    end else if (!ce_n && ale && !busy) begin
      if (nadr == 0) col[7:0] = dq_in;
      else col[15:8] = dq_in;
      nadr++;
      if (last_cmd inside {8'h90, 8'hEC, 8'hED}) begin
        fill(last_cmd, dq_in);
        ptr = 10'h000;
        if (last_cmd != 8'h90) go_busy(ARRAY_NS);
      end
    end
  end

  always @(negedge read_strobe_n) begin
    if (!ce_n && !cle && !ale) begin
      dq_oe = 1'b1;
      dq_out = stat_mode ? status : mem[ptr];
      if (!stat_mode) ptr++;
    end
  end

  // Hold time over: the line no longer shows the byte
  always @(posedge read_strobe_n) begin
    #2;
    dq_oe = 1'b0;
    dq_out = ~dq_out;
  end

  initial begin
    dq_out = 8'h00;
    dq_oe = 1'b0;
    go_busy(PWRUP_NS);
  end
endmodule : nrid_flash_model

// [nand_init_reset_ident_bench.sv]
`timescale 1ns/10ps
module nand_init_reset_ident_bench;
  localparam int PWR = 50;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic op_valid = 1'b0;
  logic op_poll = 1'b0;
  logic rd_ready = 1'b0;
  logic bad_copy0 = 1'b0;
  logic hold = 1'b0;
  logic skip = 1'b0;
  logic [2:0] op_code = 3'h0;
  logic [15:0] op_col = 16'h0000;
  logic [9:0] op_len = 10'h000;
  logic [7:0] status_q, rd_data, io_out_q, m_dq;
  logic op_ready, op_done, init_done_q, rd_valid, crc_ok_q, uid_ok_q, ce_n_q, cle_q, ale_q;
  logic write_strobe_n_q, read_strobe_n_q, io_oe_q, m_oe, ready_busy_n;
  logic [7:0] last_cmd = 8'h00;
  logic [7:0] mode_cmd = 8'h00;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n_cmd = 0;
  int exp_q[$];
  int e;
  int i;
  wire logic [7:0] io_in = io_oe_q ? io_out_q : m_dq;

  nrid_host #(.PWR_WAIT(PWR), .RST_BUSY(100)) u_nrid_host (
    .clk, .resetn, .op_valid, .op_ready, .op_code, .op_poll, .op_col, .op_len, .op_done, .status_q,
    .init_done_q, .rd_valid, .rd_ready, .rd_data, .crc_ok_q, .uid_ok_q, .ce_n_q, .cle_q, .ale_q,
    .write_strobe_n_q, .read_strobe_n_q, .io_out_q, .io_oe_q, .io_in, .ready_busy_n
  );
  nrid_flash_model u_nrid_flash_model (
    .ce_n(ce_n_q), .cle(cle_q), .ale(ale_q), .write_strobe_n(write_strobe_n_q),
    .read_strobe_n(read_strobe_n_q), .dq_in(io_in), .bad_copy0, .dq_out(m_dq), .dq_oe(m_oe), .ready_busy_n
  );

  always #2 clk = ~clk;

  task automatic check(input logic [8:0] seen, input logic [8:0] want);
    samples_checked++;
    if (seen !== want) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic report_and_stop;
    if (n_mismatch == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  task automatic give_up;
    n_mismatch++;
    $display("[ERR] %0t wait ran out", $time);
    report_and_stop();
  endtask : give_up

  // ==========================================================
  // Reference bytes: 0 id, 1 signature, 2 page (-1 = CRC), 3 unique id
  // ==========================================================
  function automatic int exp_byte(input int kind, input int j);
    case (kind)
      0: return j == 0 ? 'hA5 : j == 1 ? 'h3C : j == 2 ? 'h90 : j == 3 ? 'h95 : 'h06;
      1: return 8'(32'h4F4E4649 >> (24 - 8 * j));
      2: return j < 4 ? exp_byte(1, j) : j < 254 ? j : -1;
      default: return (j % 16) ^ (j < 16 ? 'h5A : 'hA5);
    endcase
  endfunction : exp_byte

  task automatic expect_run(input int kind, input int from, input int n);
    for (int j = from; j < from + n; j++) exp_q.push_back(exp_byte(kind, j));
  endtask : expect_run

  // Entered just after an edge; returns just after an edge
  task automatic do_op(input logic [2:0] c, input logic p, input logic [15:0] col, input logic [9:0] len);
    int k;
    op_code = c;
    op_poll = p;
    op_col = col;
    op_len = len;
    op_valid = 1'b1;
    k = 0;
    while (!op_ready && k < 30000) begin
      @(posedge clk);
      #1;
      k++;
    end
    @(posedge clk);
    #1 op_valid = 1'b0;
    while (!op_done && k < 30000) begin
      @(posedge clk);
      #1;
      k++;
    end
    while (exp_q.size() > 0 && k < 30000) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k >= 30000) give_up();
    #1;
  endtask : do_op

  always @(posedge clk) begin
    rd_ready <= #1 !hold && ($urandom % 4 != 0);
    if (rd_valid && rd_ready && !skip) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : 256;
      if (e >= 0) check({1'b0, rd_data}, 9'(e));
    end
  end

  always @(posedge write_strobe_n_q) begin
    if (!ce_n_q && cle_q) begin
      if (n_cmd == 0) check({1'b0, io_in}, 9'h0FF);
      if (last_cmd == 8'h70 && io_in != 8'h70 && mode_cmd inside {8'hEC, 8'hED}) check({1'b0, io_in}, 9'h000);
      if (io_in == 8'h78) check(9'h078, 9'h000);
      if (io_in inside {8'h90, 8'hEC, 8'hED, 8'hFF, 8'h00}) mode_cmd = io_in;
      last_cmd = io_in;
      n_cmd++;
    end
  end

  initial begin
    void'($urandom(89));
    repeat (16) @(posedge clk);
    #1 resetn = 1'b1;
    for (i = 0; !op_ready && i < 5000; i++) @(posedge clk);
    if (i >= 5000) give_up();
    check(9'(ready_busy_n), 9'h001);
    check(9'(i >= PWR), 9'h001);
    #1;
    // An order before the reset must not reach the flash
    do_op(nrid_pkg::OP_ID_MAKER, 1'b0, 16'h0000, 10'h000);
    check(9'(init_done_q), 9'h000);
    do_op(nrid_pkg::OP_RESET, 1'b0, 16'h0000, 10'h000);
    check(9'(init_done_q), 9'h001);
    do_op(nrid_pkg::OP_STATUS, 1'b0, 16'h0000, 10'h000);
    check({1'b0, status_q}, 9'h0E0);
    expect_run(0, 0, 5);
    do_op(nrid_pkg::OP_ID_MAKER, 1'b0, 16'h0000, 10'h000);
    expect_run(1, 0, 4);
    do_op(nrid_pkg::OP_ID_ONFI, 1'b0, 16'h0000, 10'h000);
    // Drain stalls long enough for the buffer to fill and push back
    hold = 1'b1;
    fork
      begin
        repeat (400) @(posedge clk);
        #1 hold = 1'b0;
      end
    join_none
    expect_run(2, 0, 256);
    do_op(nrid_pkg::OP_PARAM, 1'b0, 16'h0000, 10'h000);
    check(9'(crc_ok_q), 9'h001);
    expect_run(2, 0, 256);
    do_op(nrid_pkg::OP_PARAM, 1'b1, 16'h0000, 10'h000);
    expect_run(3, 0, 32);
    do_op(nrid_pkg::OP_UNIQUE, 1'b1, 16'h0000, 10'h000);
    check(9'(uid_ok_q), 9'h001);
    i = $urandom % 28;
    expect_run(3, i, 4);
    do_op(nrid_pkg::OP_RAND_READ, 1'b0, 16'(i), 10'h004);
    // First copies damaged: the host has to settle on a later copy
    skip = 1'b1;
    bad_copy0 = 1'b1;
    do_op(nrid_pkg::OP_PARAM, 1'b0, 16'h0000, 10'h000);
    check(9'(crc_ok_q), 9'h001);
    do_op(nrid_pkg::OP_UNIQUE, 1'b0, 16'h0000, 10'h000);
    check(9'(uid_ok_q), 9'h001);
    report_and_stop();
  end
endmodule : nand_init_reset_ident_bench
